// ---- common/sbio_pkg.sv ----
// package of constants for the system-board i/o ports block
// assumes a 100 mhz core clock and a byte-wide cpu i/o bus
//
// Summary of operation
// - 8 mhz mode: early external acknowledge still gets exactly one wait
// - no external acknowledge within 130 us means the access timed out
// - on timeout force ready to the cpu and raise nmi together
// - printer data port at 010h drives its lines inverted
// - printer data lines idle at all ones, hex ff
// - status port 011h bit 0 reads zero while printer busy
// - status port bit 2 reads one while printer selected
// - keyboard receive bit on status bit 3, send request on bit 4
// - handshake bit 0 is keyboard transmit bit, bit 1 its strobe
// - status bits 5, 6 carrier and calling lines, bit 7 motor status
// - handshake bit 2 clock select, bit 3 printer irq, bit 5 strobe
// - printer port strobed output with handshake, status port plain input
// - bit set/reset write at 013h changes one handshake bit only
// - handshake bit 6 is the acknowledge interrupt enable flag
// - sound port bit 4 drive motor active low, bits 5-7 bank select
// - port 060h: reset button on bit 1 low pressed, switches on 2-7
// - latch 070h bit 3 holds disk controller in reset while one
// - port 270h: switches 7 and 8 on bits 2 and 3, one is on
package sbio_pkg;
  // ***********************
  // addresses
  // ***********************
  localparam logic [9:0] ADDR_PRINTER_DATA = 10'h010;
  localparam logic [9:0] ADDR_STATUS_IN    = 10'h011;
  localparam logic [9:0] ADDR_HANDSHAKE    = 10'h012;
  localparam logic [9:0] ADDR_PORT_CTRL    = 10'h013;
  localparam logic [9:0] ADDR_SWITCH_IN    = 10'h060;
  localparam logic [9:0] ADDR_DISK_LATCH   = 10'h070;
  localparam logic [9:0] ADDR_SOUND_DATA   = 10'h230;
  localparam logic [9:0] ADDR_SOUND_SEL    = 10'h231;
  localparam logic [9:0] ADDR_EXTRA_SW     = 10'h270;
  // wait classes by address
  localparam logic [9:0] ADDR_SLOW_BASE    = 10'h200;
  localparam logic [9:0] ADDR_EXT_ACKNOWLEDGE_N_BASE    = 10'h380;
  // ***********************
  // fields and values
  // ***********************
  localparam int          CTRL_MODE_BIT    = 7;
  localparam int          CTRL_GA_MODE_BIT = 5;
  localparam int          CTRL_PA_DIR_BIT  = 4;
  localparam int          CTRL_PCH_DIR_BIT = 3;
  localparam int          CTRL_PCL_DIR_BIT = 0;
  localparam int          PC_IRQ_BIT       = 3;
  localparam int          PC_ACK_IRQ_ENABLE_BIT      = 6;
  localparam int          PC_OBF_BIT       = 7;
  localparam int          GP_MOTOR_BIT     = 4;
  localparam int          GP_BANK_LSB      = 5;
  localparam int          DISK_RST_BIT     = 3;
  localparam int          MIXER_IOA_BIT    = 6;
  localparam logic [7:0]  SND_REG_MIXER    = 8'h07;
  localparam logic [7:0]  SND_REG_IOA      = 8'h0e;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  localparam logic [7:0]  BYTE_ONES        = 8'hff;
  localparam logic [3:0]  NIB_ZERO         = 4'h0;
  localparam logic [3:0]  WAIT_FAST_8      = 4'h1;
  localparam logic [3:0]  WAIT_FAST_5      = 4'h0;
  localparam logic [3:0]  WAIT_SLOW        = 4'h3;
  // ***********************
  // timing
  // ***********************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int CPU8_PERIOD_NS  = 125;
  localparam int CPU5_PERIOD_NS  = 200;
  localparam int CPU8_CYC        = CPU8_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CPU5_CYC        = CPU5_PERIOD_NS / CLK_PERIOD_NS;
  localparam int EXT_ACKNOWLEDGE_N_TIMEOUT_US = 130;
  localparam int EXT_ACKNOWLEDGE_N_TIMEOUT_CYC =
    EXT_ACKNOWLEDGE_N_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
endpackage

// ---- dv/sbio_printer_model.sv ----
// printer model on the far side of the printer data port
// assumes obf_n reaches it gated high while the pin is not driven
`timescale 1ns/1ns
`default_nettype none
module sbio_printer_model (
  input  wire logic i_clock,
  input  wire logic i_obf_n,
  output logic      o_ack_n,
  output logic      o_busy_n
);
  logic       obf_q = 1'b1;
  logic [3:0] cnt   = 4'h0;
  initial o_ack_n = 1'b1;
  initial o_busy_n = 1'b1;
  // busy from new byte until ack ends; ack low three cycles
  always @(posedge i_clock) begin
    obf_q <= i_obf_n;
    if (obf_q && !i_obf_n) cnt <= 4'h9;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    o_busy_n <= (cnt == 4'h0);
    o_ack_n  <= !(cnt inside {4'h1, 4'h2, 4'h3});
  end
endmodule // sbio_printer_model
`default_nettype wire

// ---- dv/system_board_io_ports_tb.sv ----
// self-checking bench for the system-board i/o ports
// assumes sbio_pkg, the design and the printer model compiled first
`timescale 1ns/1ns
`default_nettype none
module system_board_io_ports_tb;
  import sbio_pkg::*;
  localparam int P_TO = 200;
  logic        i_clock, i_rst_b, i_io_rd, i_io_wr, i_cpu_mode_8mhz;
  logic        i_ext_acknowledge_n, i_printer_busy_n, i_printer_ack_n;
  logic        i_high_density, i_reset_button_in_n, o_io_ready, o_nmi;
  logic        o_printer_data_oe_n, o_sound_gp_oe_n, o_drive_motor_n;
  logic        o_disk_ctrl_reset, gnmi;
  logic [9:0]  i_io_addr;
  logic [7:0]  i_io_wdata, o_io_rdata, i_config_switch, o_printer_data;
  logic [7:0]  o_handshake_lines, o_handshake_oe_n, o_sound_chip_gp_port;
  logic [7:0]  got;
  logic [7:1]  st;
  logic [2:0]  o_window_bank_sel;
  logic [15:0] lfsr = 16'h023e;
  int          mismatches = 0;
  int          n_checks = 0;
  int          lat;
  int          pcb[4] = '{0, 1, 2, 5};
  sbio_ports #(.P_TIMEOUT_CYC(P_TO)) dut (.i_clock, .i_rst_b, .i_io_addr,
    .i_io_rd, .i_io_wr, .i_io_wdata, .o_io_rdata, .o_io_ready, .o_nmi,
    .i_cpu_mode_8mhz, .i_ext_acknowledge_n, .i_printer_busy_n,
    .i_paper_out_flag(st[1]), .i_printer_select_flag(st[2]),
    .i_kbd_rx_bit(st[3]), .i_kbd_send_request(st[4]),
    .i_carrier_sense_n(st[5]), .i_calling_signal(st[6]),
    .i_floppy_motor_on(st[7]), .i_printer_ack_n, .i_high_density,
    .i_reset_button_in_n, .i_config_switch, .o_printer_data,
    .o_printer_data_oe_n, .o_handshake_lines, .o_handshake_oe_n,
    .o_sound_chip_gp_port, .o_sound_gp_oe_n, .o_drive_motor_n,
    .o_window_bank_sel, .o_disk_ctrl_reset);
  sbio_printer_model prn (.i_clock,
    .i_obf_n(o_handshake_oe_n[7] | o_handshake_lines[7]),
    .o_ack_n(i_printer_ack_n), .o_busy_n(i_printer_busy_n));
  // ***********************
  // helpers
  // ***********************
  function automatic logic [15:0] rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] bsr(input int b, input logic v);
    return {4'h0, b[2:0], v};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge i_clock);
    #1;
  endtask
  // request held until ready is seen, then dropped
  task automatic io(input logic w, input logic [9:0] a, input logic [7:0] d);
    i_io_addr = a;
    i_io_wdata = d;
    i_io_wr = w;
    i_io_rd = !w;
    lat = 0;
    wt(1);
    while (o_io_ready !== 1'b1 && lat < 400) begin
      wt(1);
      lat++;
    end
    if (lat >= 400) begin
      mismatches++;
      $display("FAIL %0t no ready on access", $time);
    end
    got = o_io_rdata;
    gnmi = o_nmi;
    i_io_rd = 1'b0;
    i_io_wr = 1'b0;
    wt(2);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  initial begin
    #100000;
    mismatches++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test();
  end
  // ***********************
  // sequence
  // ***********************
  initial begin
    {i_rst_b, i_io_rd, i_io_wr, i_cpu_mode_8mhz} = 4'h0;
    {i_io_addr, i_io_wdata, st, i_config_switch} = '0;
    {i_ext_acknowledge_n, i_high_density, i_reset_button_in_n} = 3'h5;
    wt(10);
    i_rst_b = 1'b1;
    wt(5);
    chk(o_printer_data, BYTE_ONES);
    chk(o_handshake_oe_n, BYTE_ONES);
    chk({7'h0, o_printer_data_oe_n}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      lfsr = rnd(lfsr);
      {st, i_high_density, i_reset_button_in_n} = lfsr[8:0];
      i_config_switch = lfsr[15:8];
      wt(6);
      io(1'b0, ADDR_STATUS_IN, 8'h00);
      chk(got, {st, i_printer_busy_n});
      io(1'b0, ADDR_SWITCH_IN, 8'h00);
      chk(got, {i_config_switch[5:0], i_reset_button_in_n,
                i_high_density});
      io(1'b0, ADDR_EXTRA_SW, 8'h00);
      chk(got & 8'h0c, {4'h0, i_config_switch[7:6], 2'h0});
    end
    io(1'b0, 10'h018, 8'h00);
    chk(got, BYTE_ONES);
    io(1'b1, ADDR_PORT_CTRL, 8'ha2);
    chk({7'h0, o_printer_data_oe_n, o_handshake_lines[7]}, 8'h01);
    chk(o_printer_data, BYTE_ONES);
    foreach (pcb[k]) begin
      io(1'b1, ADDR_PORT_CTRL, bsr(pcb[k], 1'b1));
      chk(o_handshake_lines & 8'h27, 8'h01 << pcb[k]);
      io(1'b1, ADDR_PORT_CTRL, bsr(pcb[k], 1'b0));
    end
    io(1'b1, ADDR_PORT_CTRL, bsr(PC_ACK_IRQ_ENABLE_BIT, 1'b1));
    lfsr = rnd(lfsr);
    io(1'b1, ADDR_PRINTER_DATA, lfsr[7:0]);
    chk(o_printer_data, ~lfsr[7:0]);
    wt(30);
    chk(o_handshake_lines & 8'h88, 8'h88);
    io(1'b1, ADDR_PORT_CTRL, bsr(PC_ACK_IRQ_ENABLE_BIT, 1'b0));
    io(1'b1, ADDR_PRINTER_DATA, 8'h00);
    chk(o_printer_data, BYTE_ONES);
    wt(30);
    chk(o_handshake_lines & 8'h88, 8'h80);
    io(1'b1, ADDR_SOUND_SEL, SND_REG_IOA);
    io(1'b1, ADDR_SOUND_DATA, lfsr[15:8]);
    chk({7'h0, o_sound_gp_oe_n}, 8'h01);
    io(1'b1, ADDR_SOUND_SEL, SND_REG_MIXER);
    io(1'b1, ADDR_SOUND_DATA, 8'h40);
    chk({o_sound_gp_oe_n, o_window_bank_sel, o_drive_motor_n, 3'h0},
        {1'b0, lfsr[15:12], 3'h0});
    io(1'b1, ADDR_DISK_LATCH, 8'h08);
    chk({7'h0, o_disk_ctrl_reset}, 8'h01);
    io(1'b1, ADDR_DISK_LATCH, 8'h07);
    chk({7'h0, o_disk_ctrl_reset}, 8'h00);
    i_cpu_mode_8mhz = 1'b1;
    i_ext_acknowledge_n = 1'b0;
    wt(6);
    io(1'b0, 10'h3c0, 8'h00);
    // lat counts edges after the start edge, so latency is lat + 1
    chk({6'h0, gnmi, lat + 1 >= CPU8_CYC && lat + 1 <= CPU8_CYC + 6},
        8'h01);
    i_ext_acknowledge_n = 1'b1;
    wt(6);
    io(1'b0, 10'h3c0, 8'h00);
    chk({6'h0, gnmi, lat >= P_TO - 1 && lat <= P_TO + 2},
        8'h03);
    finish_test();
  end
endmodule // system_board_io_ports_tb
`default_nettype wire

// ---- hdl/sbio_ports.sv ----
// system-board parallel ports: printer/keyboard port, sound chip
// general port shadow, switch inputs, disk controller latch
// assumes one access at a time: rd or wr held until o_io_ready
`timescale 1ns/1ns
`default_nettype none
module sbio_ports
  import sbio_pkg::*;
#(
  parameter int unsigned P_TIMEOUT_CYC = EXT_ACKNOWLEDGE_N_TIMEOUT_CYC
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic [9:0] i_io_addr,
  input  wire logic       i_io_rd,
  input  wire logic       i_io_wr,
  input  wire logic [7:0] i_io_wdata,
  output logic      [7:0] o_io_rdata,
  output logic            o_io_ready,
  output logic            o_nmi,
  input  wire logic       i_cpu_mode_8mhz,
  input  wire logic       i_ext_acknowledge_n,
  input  wire logic       i_printer_busy_n,
  input  wire logic       i_paper_out_flag,
  input  wire logic       i_printer_select_flag,
  input  wire logic       i_kbd_rx_bit,
  input  wire logic       i_kbd_send_request,
  input  wire logic       i_carrier_sense_n,
  input  wire logic       i_calling_signal,
  input  wire logic       i_floppy_motor_on,
  input  wire logic       i_printer_ack_n,
  input  wire logic       i_high_density,
  input  wire logic       i_reset_button_in_n,
  input  wire logic [7:0] i_config_switch,
  output logic      [7:0] o_printer_data,
  output logic            o_printer_data_oe_n,
  output logic      [7:0] o_handshake_lines,
  output logic      [7:0] o_handshake_oe_n,
  output logic      [7:0] o_sound_chip_gp_port,
  output logic            o_sound_gp_oe_n,
  output logic            o_drive_motor_n,
  output logic      [2:0] o_window_bank_sel,
  output logic            o_disk_ctrl_reset
);
  // ***********************
  // input synchronisers
  // ***********************
  localparam int SW = 21;
  logic [SW-1:0] raw;
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  logic [SW-1:0] s3_reg;
  logic [SW-1:0] flt_reg;
  logic [7:0]    pb_in;
  logic [7:0]    sw_in;
  logic          ack_n;
  logic          ack_n_prev_reg;
  logic          btn_n;
  logic          hden;
  logic          ext_acknowledge_n;
  logic          mode8;

  assign raw = {i_cpu_mode_8mhz, ~i_ext_acknowledge_n, i_config_switch,
                i_high_density, i_reset_button_in_n, i_printer_ack_n,
                i_floppy_motor_on, i_calling_signal, i_carrier_sense_n,
                i_kbd_send_request, i_kbd_rx_bit, i_printer_select_flag,
                i_paper_out_flag, i_printer_busy_n};

  // a bit only moves once the second and third stage agree
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      flt_reg <= '0;
    end else begin
      s1_reg  <= raw;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      flt_reg <= (~(s2_reg ^ s3_reg) & s2_reg)
               | ((s2_reg ^ s3_reg) & flt_reg);
    end
  end

  assign pb_in = flt_reg[7:0];
  assign ack_n = flt_reg[8];
  assign btn_n = flt_reg[9];
  assign hden  = flt_reg[10];
  assign sw_in = flt_reg[18:11];
  assign ext_acknowledge_n  = flt_reg[19];
  assign mode8 = flt_reg[20];

  // ***********************
  // access decode
  // ***********************
  logic       busy;
  logic       start;
  logic       wr_go;
  logic       use_ext_acknowledge_n;
  logic [3:0] wait_cnt;

  assign start = (i_io_rd || i_io_wr) && !busy;
  assign wr_go = start && i_io_wr;
  assign use_ext_acknowledge_n = (i_io_addr >= ADDR_EXT_ACKNOWLEDGE_N_BASE);

  always_comb begin
    if (i_io_addr < ADDR_SLOW_BASE) begin
      wait_cnt = mode8 ? WAIT_FAST_8 : WAIT_FAST_5;
    end else begin
      wait_cnt = WAIT_SLOW;
    end
  end

  sbio_ready_ctl #(
    .P_TIMEOUT_CYC (P_TIMEOUT_CYC)
  ) u_ready (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_start     (start),
    .i_req       (i_io_rd || i_io_wr),
    .i_mode_8mhz (mode8),
    .i_use_ext_acknowledge_n  (use_ext_acknowledge_n),
    .i_wait_cnt  (wait_cnt),
    .i_ext_ack   (ext_acknowledge_n),
    .o_ready     (o_io_ready),
    .o_nmi       (o_nmi),
    .o_busy      (busy)
  );

  // ***********************
  // programmable port
  // ***********************
  logic       pa_out_reg;
  logic       pch_out_reg;
  logic       pcl_out_reg;
  logic       mode1_reg;
  logic [7:0] pc_latch_reg;
  logic       obf_reg;
  logic       intr_reg;
  logic       ack_rise;
  logic       ack_fall;
  logic [7:0] pc_pins;
  logic [7:0] pc_oe_n;
  logic       mode_wr;
  logic       bsr_wr;
  logic       pa_wr;

  assign mode_wr  = wr_go && i_io_addr == ADDR_PORT_CTRL
                    && i_io_wdata[CTRL_MODE_BIT];
  assign bsr_wr   = wr_go && i_io_addr == ADDR_PORT_CTRL
                    && !i_io_wdata[CTRL_MODE_BIT];
  assign pa_wr    = wr_go && i_io_addr == ADDR_PRINTER_DATA;
  assign ack_rise = ack_n && !ack_n_prev_reg;
  assign ack_fall = !ack_n && ack_n_prev_reg;

  // mode word clears the handshake latch and flags and sets printer data to ff, as a port reconfiguration must
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pa_out_reg   <= 1'b0;
      pch_out_reg  <= 1'b0;
      pcl_out_reg  <= 1'b0;
      mode1_reg    <= 1'b0;
      pc_latch_reg <= BYTE_ZERO;
    end else if (mode_wr) begin
      pa_out_reg   <= !i_io_wdata[CTRL_PA_DIR_BIT];
      pch_out_reg  <= !i_io_wdata[CTRL_PCH_DIR_BIT];
      pcl_out_reg  <= !i_io_wdata[CTRL_PCL_DIR_BIT];
      mode1_reg    <= i_io_wdata[CTRL_GA_MODE_BIT];
      pc_latch_reg <= BYTE_ZERO;
    end else if (bsr_wr) begin
      pc_latch_reg[i_io_wdata[3:1]] <= i_io_wdata[0];
    end
  end

  // output buffer full / ack interrupt handshake; set beats clear
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      obf_reg        <= 1'b0;
      intr_reg       <= 1'b0;
      ack_n_prev_reg <= 1'b1;
    end else begin
      ack_n_prev_reg <= ack_n;
      if (mode_wr) begin
        obf_reg  <= 1'b0;
        intr_reg <= 1'b0;
      end else begin
        if (pa_wr) begin
          obf_reg <= 1'b1;
        end else if (ack_fall) begin
          obf_reg <= 1'b0;
        end
        if (mode1_reg && ack_rise && pc_latch_reg[PC_ACK_IRQ_ENABLE_BIT]) begin
          intr_reg <= 1'b1;
        end else if (pa_wr) begin
          intr_reg <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    pc_pins = pc_latch_reg;
    pc_oe_n = {{4{!pch_out_reg}}, {4{!pcl_out_reg}}};
    if (mode1_reg) begin
      pc_pins[PC_IRQ_BIT]  = intr_reg;
      pc_pins[PC_OBF_BIT]  = !obf_reg;
      pc_pins[PC_ACK_IRQ_ENABLE_BIT] = pc_latch_reg[PC_ACK_IRQ_ENABLE_BIT];
      pc_oe_n[PC_IRQ_BIT]  = 1'b0;
      pc_oe_n[PC_OBF_BIT]  = 1'b0;
      pc_oe_n[PC_ACK_IRQ_ENABLE_BIT] = 1'b1;
    end
  end

  // printer lines carry the complement; cleared latch idles at ff
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_printer_data      <= BYTE_ONES;
      o_printer_data_oe_n <= 1'b1;
      o_handshake_lines   <= BYTE_ZERO;
      o_handshake_oe_n    <= BYTE_ONES;
    end else begin
      if (mode_wr) begin
        o_printer_data <= BYTE_ONES;
      end else if (pa_wr) begin
        o_printer_data <= ~i_io_wdata;
      end
      o_printer_data_oe_n <= !pa_out_reg;
      o_handshake_lines   <= pc_pins;
      o_handshake_oe_n    <= pc_oe_n;
    end
  end

  // ***********************
  // sound chip port and latches
  // ***********************
  logic [7:0] snd_sel_reg;
  logic [7:0] snd_mix_reg;
  logic [7:0] snd_ioa_reg;
  logic [3:0] disk_latch_reg;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      snd_sel_reg    <= BYTE_ZERO;
      snd_mix_reg    <= BYTE_ZERO;
      snd_ioa_reg    <= BYTE_ZERO;
      disk_latch_reg <= NIB_ZERO;
    end else if (wr_go) begin
      if (i_io_addr == ADDR_SOUND_SEL) begin
        snd_sel_reg <= i_io_wdata;
      end
      if (i_io_addr == ADDR_SOUND_DATA && snd_sel_reg == SND_REG_MIXER) begin
        snd_mix_reg <= i_io_wdata;
      end
      if (i_io_addr == ADDR_SOUND_DATA && snd_sel_reg == SND_REG_IOA) begin
        snd_ioa_reg <= i_io_wdata;
      end
      if (i_io_addr == ADDR_DISK_LATCH) begin
        disk_latch_reg <= i_io_wdata[3:0];
      end
    end
  end

  // pins follow the stored values one cycle later
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sound_chip_gp_port <= BYTE_ZERO;
      o_sound_gp_oe_n      <= 1'b1;
      o_drive_motor_n      <= 1'b1;
      o_window_bank_sel    <= 3'h0;
      o_disk_ctrl_reset    <= 1'b0;
    end else begin
      o_sound_chip_gp_port <= snd_ioa_reg;
      o_sound_gp_oe_n      <= !snd_mix_reg[MIXER_IOA_BIT];
      o_drive_motor_n      <= snd_ioa_reg[GP_MOTOR_BIT];
      o_window_bank_sel    <= snd_ioa_reg[GP_BANK_LSB +: 3];
      o_disk_ctrl_reset    <= disk_latch_reg[DISK_RST_BIT];
    end
  end

  // ***********************
  // read data
  // ***********************
  logic [7:0] rdata_next;

  // reads have no side effects; unmapped addresses float high
  always_comb begin
    case (i_io_addr)
      ADDR_PRINTER_DATA: rdata_next = ~o_printer_data;
      ADDR_STATUS_IN:    rdata_next = pb_in;
      ADDR_HANDSHAKE:    rdata_next = {pc_pins[7], mode1_reg ?
                           pc_latch_reg[PC_ACK_IRQ_ENABLE_BIT] : ack_n,
                           pc_pins[5:0]};
      ADDR_SWITCH_IN:    rdata_next = {sw_in[5:0], btn_n, hden};
      ADDR_EXTRA_SW:     rdata_next = {4'h0, sw_in[7:6], 2'h0};
      ADDR_SOUND_DATA:   rdata_next = (snd_sel_reg == SND_REG_IOA) ?
                           snd_ioa_reg : snd_mix_reg;
      default:           rdata_next = BYTE_ONES;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_io_rdata <= BYTE_ONES;
    end else if (start && i_io_rd) begin
      o_io_rdata <= rdata_next;
    end
  end

  // ***********************
  // checks
  // ***********************
  a_pa_inverted: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    pa_wr && !mode_wr |=> o_printer_data == ~$past(i_io_wdata))
    else $error("printer data not complemented");

  a_pa_idle_ones: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    mode_wr |=> o_printer_data == BYTE_ONES)
    else $error("printer data not idle after mode write");

  a_busy_read: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    start && i_io_rd && i_io_addr == ADDR_STATUS_IN
    |=> o_io_rdata[0] == $past(flt_reg[0])
        && o_io_rdata[2] == $past(flt_reg[2]))
    else $error("status port busy or select bit wrong");

  a_bsr_one_bit: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    bsr_wr |=> (pc_latch_reg ^ $past(pc_latch_reg))
               == (($past(i_io_wdata[0])
                    ^ $past(pc_latch_reg[i_io_wdata[3:1]]))
                   << $past(i_io_wdata[3:1])))
    else $error("bit set/reset touched other bits");

  a_switch_read: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    start && i_io_rd && i_io_addr == ADDR_SWITCH_IN
    |=> o_io_rdata[7:1] == $past({sw_in[5:0], btn_n}))
    else $error("switch port read wrong");

  a_disk_reset: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    wr_go && i_io_addr == ADDR_DISK_LATCH
    |=> ##1 o_disk_ctrl_reset == $past(i_io_wdata[DISK_RST_BIT], 2))
    else $error("disk controller reset does not follow latch");
endmodule // sbio_ports
`default_nettype wire

// ---- hdl/sbio_ready_ctl.sv ----
// ready and timeout sequencer for one cpu i/o access
// assumes the request level stays up until ready has been seen
`timescale 1ns/1ns
`default_nettype none
module sbio_ready_ctl
  import sbio_pkg::*;
#(
  parameter int unsigned P_TIMEOUT_CYC = EXT_ACKNOWLEDGE_N_TIMEOUT_CYC
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_start,
  input  wire logic       i_req,
  input  wire logic       i_mode_8mhz,
  input  wire logic       i_use_ext_acknowledge_n,
  input  wire logic [3:0] i_wait_cnt,
  input  wire logic       i_ext_ack,
  output logic            o_ready,
  output logic            o_nmi,
  output logic            o_busy
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_EXT_ACKNOWLEDGE_N, ST_HOLD
  } sbio_rdy_state_t;

  localparam int TW = $clog2(P_TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(P_TIMEOUT_CYC - 1);
  localparam logic [4:0] DIV8_LAST = 5'(CPU8_CYC - 1);
  localparam logic [4:0] DIV5_LAST = 5'(CPU5_CYC - 1);

  sbio_rdy_state_t state_reg;
  logic [4:0]      div_reg;
  logic [3:0]      wait_reg;
  logic [TW-1:0]   tmo_reg;
  logic            first_reg;
  logic            tick;

  // ***********************
  // cpu clock enable
  // ***********************
  // restarted per access so wait states line up with the cycle start
  assign tick = (div_reg == (i_mode_8mhz ? DIV8_LAST : DIV5_LAST));

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_reg <= 5'h00;
    end else if (i_start || tick) begin
      div_reg <= 5'h00;
    end else begin
      div_reg <= div_reg + 5'h01;
    end
  end

  // ***********************
  // sequencer
  // ***********************
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= ST_IDLE;
      wait_reg  <= 4'h0;
      tmo_reg   <= '0;
      first_reg <= 1'b0;
      o_ready   <= 1'b0;
      o_nmi     <= 1'b0;
      o_busy    <= 1'b0;
    end else begin
      o_ready <= 1'b0;
      o_nmi   <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (i_start) begin
            o_busy    <= 1'b1;
            wait_reg  <= i_wait_cnt;
            tmo_reg   <= '0;
            first_reg <= 1'b1;
            if (i_use_ext_acknowledge_n) begin
              state_reg <= ST_EXT_ACKNOWLEDGE_N;
            end else if (i_wait_cnt == 4'h0) begin
              o_ready   <= 1'b1;
              state_reg <= ST_HOLD;
            end else begin
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (tick) begin
            if (wait_reg == 4'h1) begin
              o_ready   <= 1'b1;
              state_reg <= ST_HOLD;
            end else begin
              wait_reg <= wait_reg - 4'h1;
            end
          end
        end
        ST_EXT_ACKNOWLEDGE_N: begin
          tmo_reg <= tmo_reg + TW'(1);
          if (tick) begin
            first_reg <= 1'b0;
          end
          if (i_ext_ack && i_mode_8mhz && first_reg) begin
            wait_reg  <= 4'h1;
            state_reg <= ST_WAIT;
          end else if (i_ext_ack) begin
            o_ready   <= 1'b1;
            state_reg <= ST_HOLD;
          end else if (tmo_reg == TMO_LAST) begin
            o_ready   <= 1'b1;
            o_nmi     <= 1'b1;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!i_req) begin
            o_busy    <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  a_nmi_with_ready: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    o_nmi |-> o_ready && $past(state_reg) == ST_EXT_ACKNOWLEDGE_N
                      && $past(tmo_reg) == TMO_LAST)
    else $error("nmi without forced ready at timeout");

  a_early_ack_wait: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    state_reg == ST_EXT_ACKNOWLEDGE_N && i_ext_ack && i_mode_8mhz && first_reg
    |=> state_reg == ST_WAIT && !o_ready && wait_reg == 4'h1)
    else $error("early acknowledge in 8 mhz mode skipped its wait");
endmodule // sbio_ready_ctl
`default_nettype wire
